// [hdl/mti_core.sv]
`timescale 1ns/1ps
`default_nettype none
module mti_core (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic program_rom_masked,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [2:0] instr_length,
  output mti_pkg::mti_mem_req_t mem,
  output logic [7:0] flags_out,
  output logic [7:0] rf_peek
);
  typedef enum logic [1:0] {MTI_IDLE, MTI_ACCESS, MTI_WAIT, MTI_FINISH} mti_state_t;

  typedef struct packed {
    mti_state_t state;
    mti_pkg::mti_decode_t dec;
    logic [3:0] reg_a;
    logic [3:0] reg_b;
    logic [15:0] addr;
    logic [4:0] count;
    logic done;
    logic illegal;
    mti_pkg::mti_mem_req_t mem;
    logic [7:0] flags;
  } mti_core_state_t;

  // Sixteen working registers; pairs are even/odd with the even one high.
  logic [7:0] regs [0:15];
  logic [7:0] next_regs [0:15];
  mti_core_state_t st;
  mti_core_state_t next_st;
  mti_pkg::mti_decode_t dec_now;

  function automatic logic [15:0] mti_pair(input logic [3:0] f, input logic [7:0] r [0:15]);
    mti_pair = {r[{f[3:1], 1'b0}], r[{f[3:1], 1'b1}]};
  endfunction

  function automatic logic [15:0] mti_stepped(input logic [15:0] v, input mti_pkg::mti_step_t s);
    case (s)
      mti_pkg::MTI_STEP_DEC: mti_stepped = v - 16'h0001;
      mti_pkg::MTI_STEP_INC: mti_stepped = v + 16'h0001;
      default: mti_stepped = v;
    endcase
  endfunction

  mti_decode u_decode (
    .opcode(opcode),
    .operand(operand),
    .byte2(byte2),
    .byte3(byte3),
    .program_rom_masked(program_rom_masked),
    .dec(dec_now)
  );

  always_comb begin
    logic [15:0] base;
    logic [15:0] pairv;
    logic [3:0] even_b;
    logic [3:0] src_f;
    base = 16'h0000;
    pairv = 16'h0000;
    even_b = 4'h0;
    src_f = 4'h0;
    next_st = st;
    next_st.done = 1'b0;
    for (int i = 0; i < 16; i++) begin
      next_regs[i] = regs[i];
    end
    case (st.state)
      MTI_IDLE: begin
        next_st.mem.req = 1'b0;
        if (start) begin
          next_st.dec = dec_now;
          next_st.reg_a = operand[7:4];
          next_st.reg_b = operand[3:0];
          next_st.count = dec_now.cycles - 5'h01;
          next_st.illegal = dec_now.illegal;
          if (dec_now.illegal) begin
            next_st.state = MTI_FINISH;
          end else if (dec_now.is_word) begin
            next_st.state = MTI_WAIT;
          end else begin
            pairv = mti_pair(operand[3:0], regs);
            if (dec_now.pre_step) begin
              base = mti_stepped(pairv, dec_now.step);
            end else if (dec_now.use_pair) begin
              base = pairv + dec_now.offset;
            end else begin
              base = dec_now.offset;
            end
            next_st.addr = base;
            next_st.state = MTI_ACCESS;
          end
        end
      end
      MTI_ACCESS: begin
        next_st.mem.req = 1'b1;
        next_st.mem.write = st.dec.is_store;
        next_st.mem.data_space = st.dec.data_space;
        next_st.mem.addr = st.addr;
        next_st.mem.wdata = regs[st.reg_a];
        next_st.count = st.count - 5'h01;
        next_st.state = MTI_WAIT;
      end
      MTI_WAIT: begin
        next_st.mem.req = 1'b0;
        next_st.count = st.count - 5'h01;
        if (st.count == 5'h01) begin
          next_st.state = MTI_FINISH;
        end
      end
      MTI_FINISH: begin
        next_st.state = MTI_IDLE;
        next_st.done = 1'b1;
        if (!st.illegal) begin
          if (st.dec.is_word) begin
            if (st.dec.length == mti_pkg::LEN_WORD_IMM) begin
              pairv = st.dec.offset;
              even_b = {st.reg_b[3:1], 1'b0};
            end else begin
              // The indirect form reads the pair whose address the source register holds.
              src_f = st.dec.use_pair ? st.reg_b : regs[st.reg_b][3:0];
              pairv = mti_pair(src_f, regs);
              even_b = {st.dec.offset[3:1], 1'b0};
            end
            next_regs[even_b] = pairv[15:8];
            next_regs[{even_b[3:1], 1'b1}] = pairv[7:0];
          end else begin
            // A store skips the data write-back, so its source stays intact unless it lies in the stepped pair.
            if (!st.dec.is_store) begin
              next_regs[st.reg_a] = mem_rdata;
            end
            if (st.dec.step != mti_pkg::MTI_STEP_NONE) begin
              pairv = st.dec.pre_step ? st.addr :
                      mti_stepped(st.addr, st.dec.step);
              next_regs[{st.reg_b[3:1], 1'b0}] = pairv[15:8];
              next_regs[{st.reg_b[3:1], 1'b1}] = pairv[7:0];
            end
          end
        end
      end
      default: begin
        next_st.state = MTI_IDLE;
      end
    endcase
    next_st.flags = flags_in;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      st <= next_st;
      for (int i = 0; i < 16; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  assign busy = (st.state != MTI_IDLE);
  assign done = st.done;
  assign illegal = st.illegal;
  assign instr_length = st.dec.length;
  assign mem = st.mem;
  assign flags_out = st.flags;
  assign rf_peek = regs[st.reg_a];

  property p_flags_kept;
    @(posedge core_clk) disable iff (!resetn) 1'b1 |=> flags_out == $past(flags_in);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  property p_post_inc;
    @(posedge core_clk) disable iff (!resetn)
      (start && !busy && opcode == mti_pkg::OP_LOAD_POST_INC && !dec_now.illegal)
      |-> ##11 done;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment timing");

  property p_load_pair_time;
    @(posedge core_clk) disable iff (!resetn)
      (start && !busy && opcode == mti_pkg::OP_LOAD_PAIR && !dec_now.illegal)
      |-> ##11 done;
  endproperty
  a_load_pair_time: assert property (p_load_pair_time) else $error("pair load timing");

  property p_short_length;
    @(posedge core_clk) disable iff (!resetn)
      (start && !busy &&
       (opcode == mti_pkg::OP_LOAD_SHORT || opcode == mti_pkg::OP_STORE_SHORT))
      |=> instr_length == mti_pkg::LEN_SHORT;
  endproperty
  a_short_length: assert property (p_short_length) else $error("short length");

  property p_long_length;
    @(posedge core_clk) disable iff (!resetn)
      (start && !busy &&
       (opcode == mti_pkg::OP_LOAD_LONG || opcode == mti_pkg::OP_STORE_LONG))
      |=> instr_length == mti_pkg::LEN_LONG;
  endproperty
  a_long_length: assert property (p_long_length) else $error("long length");

  property p_pre_dec;
    @(posedge core_clk) disable iff (!resetn)
      (start && !busy && opcode == mti_pkg::OP_STORE_PRE_DEC && !dec_now.illegal)
      |-> ##15 done;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement timing");

  property p_masked_store;
    @(posedge core_clk) disable iff (!resetn)
      (mem.req && mem.write) |-> !(program_rom_masked && !mem.data_space);
  endproperty
  a_masked_store: assert property (p_masked_store) else $error("rom store");
endmodule
`default_nettype wire

// [hdl/mti_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module mti_decode (
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic program_rom_masked,
  output mti_pkg::mti_decode_t dec
);
  logic [3:0] pair_field;

  always_comb begin
    pair_field = operand[3:0];
    dec = '0;
    dec.valid = 1'b1;
    dec.step = mti_pkg::MTI_STEP_NONE;
    dec.data_space = pair_field[0];
    dec.use_pair = 1'b1;
    case (opcode)
      mti_pkg::OP_LOAD_PAIR, mti_pkg::OP_STORE_PAIR: begin
        dec.is_store = (opcode == mti_pkg::OP_STORE_PAIR);
        dec.cycles = mti_pkg::CYCLES_PAIR;
        dec.length = mti_pkg::LEN_PAIR;
      end
      mti_pkg::OP_LOAD_SHORT, mti_pkg::OP_STORE_SHORT: begin
        dec.is_store = (opcode == mti_pkg::OP_STORE_SHORT);
        dec.offset = {8'h00, byte2};
        dec.cycles = mti_pkg::CYCLES_SHORT;
        dec.length = mti_pkg::LEN_SHORT;
      end
      mti_pkg::OP_LOAD_LONG, mti_pkg::OP_STORE_LONG: begin
        dec.is_store = (opcode == mti_pkg::OP_STORE_LONG);
        dec.cycles = mti_pkg::CYCLES_LONG;
        dec.length = mti_pkg::LEN_LONG;
        dec.offset = {byte3, byte2};
        // Pair fields 0 and 1 select the direct forms, never pair 0-1 as a base.
        if (pair_field == mti_pkg::DIRECT_PROGRAM_FIELD ||
            pair_field == mti_pkg::DIRECT_DATA_FIELD) begin
          dec.use_pair = 1'b0;
          dec.data_space = (pair_field == mti_pkg::DIRECT_DATA_FIELD);
        end
      end
      mti_pkg::OP_LOAD_POST_DEC, mti_pkg::OP_LOAD_POST_INC: begin
        dec.step = (opcode == mti_pkg::OP_LOAD_POST_DEC) ?
                   mti_pkg::MTI_STEP_DEC : mti_pkg::MTI_STEP_INC;
        dec.cycles = mti_pkg::CYCLES_POST;
        dec.length = mti_pkg::LEN_PAIR;
      end
      mti_pkg::OP_STORE_PRE_DEC, mti_pkg::OP_STORE_PRE_INC: begin
        dec.is_store = 1'b1;
        dec.pre_step = 1'b1;
        dec.step = (opcode == mti_pkg::OP_STORE_PRE_DEC) ?
                   mti_pkg::MTI_STEP_DEC : mti_pkg::MTI_STEP_INC;
        dec.cycles = mti_pkg::CYCLES_PRE;
        dec.length = mti_pkg::LEN_PAIR;
      end
      mti_pkg::OP_WORD_PAIR, mti_pkg::OP_WORD_INDIRECT: begin
        dec.is_word = 1'b1;
        dec.cycles = mti_pkg::CYCLES_WORD;
        dec.length = mti_pkg::LEN_WORD_REG;
        // The third byte names the destination; a clear use_pair marks the indirect source.
        dec.offset = {8'h00, byte2};
        dec.use_pair = (opcode == mti_pkg::OP_WORD_PAIR);
      end
      mti_pkg::OP_WORD_IMMEDIATE: begin
        dec.is_word = 1'b1;
        dec.cycles = mti_pkg::CYCLES_WORD;
        dec.length = mti_pkg::LEN_WORD_IMM;
        dec.offset = {byte2, byte3};
      end
      default: begin
        dec.valid = 1'b0;
      end
    endcase
    // Program stores are removed entirely on masked-ROM parts.
    if (dec.valid && dec.is_store && !dec.data_space && program_rom_masked) begin
      dec.illegal = 1'b1;
    end
    if (!dec.valid) begin
      dec.illegal = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/mti_pkg.sv]
package mti_pkg;
  localparam logic [7:0] OP_LOAD_PAIR = 8'hC3;
  localparam logic [7:0] OP_STORE_PAIR = 8'hD3;
  localparam logic [7:0] OP_LOAD_SHORT = 8'hE7;
  localparam logic [7:0] OP_STORE_SHORT = 8'hF7;
  localparam logic [7:0] OP_LOAD_LONG = 8'hA7;
  localparam logic [7:0] OP_STORE_LONG = 8'hB7;
  localparam logic [7:0] OP_LOAD_POST_DEC = 8'hE2;
  localparam logic [7:0] OP_LOAD_POST_INC = 8'hE3;
  localparam logic [7:0] OP_STORE_PRE_DEC = 8'hF2;
  localparam logic [7:0] OP_STORE_PRE_INC = 8'hF3;
  localparam logic [7:0] OP_WORD_PAIR = 8'hC4;
  localparam logic [7:0] OP_WORD_INDIRECT = 8'hC5;
  localparam logic [7:0] OP_WORD_IMMEDIATE = 8'hC6;
  localparam logic [3:0] DIRECT_PROGRAM_FIELD = 4'h0;
  localparam logic [3:0] DIRECT_DATA_FIELD = 4'h1;
  localparam logic [4:0] CYCLES_PAIR = 5'h0A;
  localparam logic [4:0] CYCLES_SHORT = 5'h0C;
  localparam logic [4:0] CYCLES_LONG = 5'h0E;
  localparam logic [4:0] CYCLES_POST = 5'h0A;
  localparam logic [4:0] CYCLES_PRE = 5'h0E;
  localparam logic [4:0] CYCLES_WORD = 5'h08;
  localparam logic [2:0] LEN_PAIR = 3'h2;
  localparam logic [2:0] LEN_SHORT = 3'h3;
  localparam logic [2:0] LEN_LONG = 3'h4;
  localparam logic [2:0] LEN_WORD_REG = 3'h3;
  localparam logic [2:0] LEN_WORD_IMM = 3'h4;

  typedef enum logic [1:0] {MTI_STEP_NONE, MTI_STEP_DEC, MTI_STEP_INC} mti_step_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic is_word;
    logic is_store;
    logic use_pair;
    logic data_space;
    logic pre_step;
    mti_step_t step;
    logic [15:0] offset;
    logic [4:0] cycles;
    logic [2:0] length;
  } mti_decode_t;

  typedef struct packed {
    logic req;
    logic write;
    logic data_space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mti_mem_req_t;
endpackage

// [tb/memory_transfer_instructions_test.sv]
`timescale 1ns/1ps
`default_nettype none
module memory_transfer_instructions_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand = 8'h00;
  logic [7:0] byte2 = 8'h00;
  logic [7:0] byte3 = 8'h00;
  logic program_rom_masked = 1'b0;
  logic [7:0] flags_in = 8'hC5;
  logic [7:0] mem_rdata;
  logic busy;
  logic done;
  logic illegal;
  logic [2:0] instr_length;
  mti_pkg::mti_mem_req_t mem;
  logic [7:0] flags_out;
  logic [7:0] rf_peek;
  int n_errors = 0;
  int compares = 0;

  always #12.5 core_clk = ~core_clk;

  mti_core uut (.core_clk(core_clk), .resetn(resetn), .start(start), .opcode(opcode),
    .operand(operand), .byte2(byte2), .byte3(byte3), .program_rom_masked(program_rom_masked),
    .flags_in(flags_in), .mem_rdata(mem_rdata), .busy(busy), .done(done), .illegal(illegal),
    .instr_length(instr_length), .mem(mem), .flags_out(flags_out), .rf_peek(rf_peek));

  mti_mem_model far (.core_clk(core_clk), .resetn(resetn), .mem(mem), .busy(busy),
    .mem_rdata(mem_rdata));

  task automatic final_report();
    $display("Checks %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    #2;
    resetn = 1'b0;
    repeat (8) @(posedge core_clk);
    #2;
    resetn = 1'b1;
  endtask

  // A count of 1 means the instruction is expected to be refused; done follows one edge later.
  task automatic exec(input logic [7:0] op, opd, b2, b3, input int cyc, input logic [2:0] len,
    input logic rq, wr, ds, input logic [15:0] ad, input logic [7:0] wd);
    int n;
    logic seen;
    mti_pkg::mti_mem_req_t cap;
    seen = 1'b0;
    cap = '0;
    opcode = op;
    operand = opd;
    byte2 = b2;
    byte3 = b3;
    start = 1'b1;
    @(posedge core_clk);
    #2;
    start = 1'b0;
    n = 0;
    while (n < 40 && done !== 1'b1) begin
      if (mem.req === 1'b1) begin
        seen = 1'b1;
        cap = mem;
      end
      @(posedge core_clk);
      #2;
      n++;
    end
    chk("cycles", cyc, n);
    chk("illegal", cyc == 1, illegal);
    if (cyc != 1) chk("length", len, instr_length);
    chk("access", rq, seen);
    if (rq) begin
      chk("write", wr, cap.write);
      chk("space", ds, cap.data_space);
      chk("addr", ad, cap.addr);
      if (wr) chk("wdata", wd, cap.wdata);
    end
    chk("flags", flags_in, flags_out);
    if (n >= 40) final_report();
  endtask

  task automatic t_stepping();
    do_reset();
    exec(8'hE2, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h0000, 8'h00);
    chk("rdata", 8'hA5, rf_peek);
    exec(8'hE2, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'hFFFF, 8'h00);
    exec(8'hE3, 8'h87, 8'h00, 8'h00, 10, 3'h2, 1, 0, 1, 16'hFFFE, 8'h00);
    exec(8'hE3, 8'h87, 8'h00, 8'h00, 10, 3'h2, 1, 0, 1, 16'hFFFF, 8'h00);
    exec(8'hF2, 8'h86, 8'h00, 8'h00, 14, 3'h2, 1, 1, 0, 16'hFFFF, 8'h5A);
    chk("source kept", 8'h5A, rf_peek);
    exec(8'hF3, 8'h87, 8'h00, 8'h00, 14, 3'h2, 1, 1, 1, 16'h0000, 8'h5A);
    exec(8'hE3, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h0000, 8'h00);
    $display("Test stepping done");
  endtask

  task automatic t_indexed();
    do_reset();
    flags_in = 8'h3A;
    exec(8'hE7, 8'h86, 8'hFF, 8'h00, 12, 3'h3, 1, 0, 0, 16'h00FF, 8'h00);
    exec(8'hF7, 8'h87, 8'hFF, 8'h00, 12, 3'h3, 1, 1, 1, 16'h00FF, 8'h5A);
    exec(8'hA7, 8'h82, 8'h34, 8'h12, 14, 3'h4, 1, 0, 0, 16'h1234, 8'h00);
    exec(8'hA7, 8'h80, 8'h78, 8'h56, 14, 3'h4, 1, 0, 0, 16'h5678, 8'h00);
    exec(8'hA7, 8'h81, 8'h78, 8'h56, 14, 3'h4, 1, 0, 1, 16'h5678, 8'h00);
    chk("rdata", 8'h74, rf_peek);
    exec(8'hB7, 8'h81, 8'h79, 8'h56, 14, 3'h4, 1, 1, 1, 16'h5679, 8'h74);
    exec(8'hB7, 8'h80, 8'h79, 8'h56, 14, 3'h4, 1, 1, 0, 16'h5679, 8'h74);
    exec(8'hC3, 8'h82, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h0000, 8'h00);
    $display("Test indexed and direct done");
  endtask

  task automatic t_masked();
    do_reset();
    program_rom_masked = 1'b1;
    exec(8'hD3, 8'h86, 8'h00, 8'h00, 1, 3'h2, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hD3, 8'h87, 8'h00, 8'h00, 10, 3'h2, 1, 1, 1, 16'h0000, 8'h00);
    exec(8'hB7, 8'h80, 8'h00, 8'h20, 1, 3'h4, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hF3, 8'h87, 8'h00, 8'h00, 14, 3'h2, 1, 1, 1, 16'h0001, 8'h00);
    exec(8'hF2, 8'h86, 8'h00, 8'h00, 1, 3'h2, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hE3, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h0001, 8'h00);
    exec(8'hFF, 8'h00, 8'h00, 8'h00, 1, 3'h1, 0, 0, 0, 16'h0000, 8'h00);
    program_rom_masked = 1'b0;
    $display("Test masked program memory done");
  endtask

  task automatic t_word();
    do_reset();
    exec(8'hC6, 8'h06, 8'h12, 8'h34, 8, 3'h4, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hE3, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h1234, 8'h00);
    exec(8'hC4, 8'h06, 8'h08, 8'h00, 8, 3'h3, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hE3, 8'h88, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h1235, 8'h00);
    exec(8'hE3, 8'h86, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h1235, 8'h00);
    exec(8'hC5, 8'h07, 8'h0A, 8'h00, 8, 3'h3, 0, 0, 0, 16'h0000, 8'h00);
    exec(8'hE3, 8'h8A, 8'h00, 8'h00, 10, 3'h2, 1, 0, 0, 16'h1236, 8'h00);
    $display("Test word load done");
  endtask

  initial begin
    t_stepping();
    t_indexed();
    t_masked();
    t_word();
    final_report();
  end
endmodule
`default_nettype wire

// [tb/mti_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mti_mem_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire mti_pkg::mti_mem_req_t mem,
  input wire logic busy,
  output logic [7:0] mem_rdata
);
  // One byte per address in each space, with a flag for bytes already written.
  logic [7:0] store [0:131071];
  logic written [0:131071];
  logic held;
  logic [7:0] data;
  logic [7:0] last;

  // Unwritten bytes hold a pattern that differs between the two spaces.
  function automatic logic [7:0] pattern_val(input logic [16:0] k);
    return k[7:0] ^ k[15:8] ^ (k[16] ? 8'h5A : 8'hA5);
  endfunction

  initial begin
    for (int i = 0; i < 131072; i++) begin
      written[i] = 1'b0;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      held <= 1'b0;
      data <= 8'h00;
      last <= 8'h00;
    end else if (mem.req) begin
      held <= 1'b1;
      if (mem.write) begin
        store[{mem.data_space, mem.addr}] <= mem.wdata;
        written[{mem.data_space, mem.addr}] <= 1'b1;
        data <= mem.wdata;
      end else if (written[{mem.data_space, mem.addr}]) begin
        data <= store[{mem.data_space, mem.addr}];
      end else begin
        data <= pattern_val({mem.data_space, mem.addr});
      end
    end else if (!busy) begin
      held <= 1'b0;
    end else begin
      last <= data;
    end
  end

  // The byte is held until the core goes idle, then the bus shows it inverted, so a late sample is caught.
  assign mem_rdata = held ? data : ~last;
endmodule
`default_nettype wire
